// >>> src/irfb_top.sv
// interrupt request flag bank: four pending flag registers, a register port and an interrupt summary.
// assumes all request strobes come from logic on MCLK; pin edge detection lives upstream.
`timescale 1ns/1ps
`default_nettype none
module irfb_top
  import irfb_pkg::*;
(
  // clock and reset
  input  wire logic               MCLK,
  input  wire logic               NRST,
  // register port
  input  wire logic [IRFB_AW-1:0] ADDR,
  input  wire logic [IRFB_DW-1:0] WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  output logic      [IRFB_DW-1:0] RDATA,
  // requests, register 0 sources
  input  wire logic               CONVERTER_DONE_REQ,
  input  wire logic               SERIAL1_TRANSMIT_REQ,
  input  wire logic               SERIAL1_RECEIVE_REQ,
  input  wire logic               SYNC_SERIAL1_EVENT_REQ,
  input  wire logic               SYNC_SERIAL1_FAULT_REQ,
  input  wire logic               TIMER_THREE_REQ,
  input  wire logic               TIMER_TWO_REQ,
  input  wire logic               COMPARE_TWO_REQ,
  input  wire logic               CAPTURE_TWO_REQ,
  input  wire logic               TIMER_ONE_REQ,
  input  wire logic               COMPARE_ONE_REQ,
  input  wire logic               CAPTURE_ONE_REQ,
  input  wire logic               EXT_LINE0_REQ,
  // requests, register 1 sources
  input  wire logic               SERIAL2_TRANSMIT_REQ,
  input  wire logic               SERIAL2_RECEIVE_REQ,
  input  wire logic               EXT_LINE2_REQ,
  input  wire logic               TIMER_FIVE_REQ,
  input  wire logic               TIMER_FOUR_REQ,
  input  wire logic               COMPARE_FOUR_REQ,
  input  wire logic               COMPARE_THREE_REQ,
  input  wire logic               EXT_LINE1_REQ,
  input  wire logic               PIN_CHANGE_REQ,
  input  wire logic               COMPARATOR_REQ,
  input  wire logic               TWOWIRE1_MASTER_REQ,
  input  wire logic               TWOWIRE1_SLAVE_REQ,
  // requests, register 2 sources
  input  wire logic               PARALLEL_PORT_REQ,
  input  wire logic               COMPARE_FIVE_REQ,
  input  wire logic               CAPTURE_FIVE_REQ,
  input  wire logic               CAPTURE_FOUR_REQ,
  input  wire logic               CAPTURE_THREE_REQ,
  input  wire logic               SYNC_SERIAL2_EVENT_REQ,
  input  wire logic               SYNC_SERIAL2_FAULT_REQ,
  // requests, register 3 sources
  input  wire logic               CALENDAR_CLOCK_REQ,
  input  wire logic               EXT_LINE4_REQ,
  input  wire logic               EXT_LINE3_REQ,
  input  wire logic               TWOWIRE2_MASTER_REQ,
  input  wire logic               TWOWIRE2_SLAVE_REQ,
  // pending flags toward enable and priority logic
  output logic      [IRFB_DW-1:0] PENDING_FLAGS_0,
  output logic      [IRFB_DW-1:0] PENDING_FLAGS_1,
  output logic      [IRFB_DW-1:0] PENDING_FLAGS_2,
  output logic      [IRFB_DW-1:0] PENDING_FLAGS_3,
  // summary interrupt
  output logic                    IRQ
);

  // ==========================================================================
  // request packing into register layout
  logic [IRFB_DW-1:0] set_0;
  logic [IRFB_DW-1:0] set_1;
  logic [IRFB_DW-1:0] set_2;
  logic [IRFB_DW-1:0] set_3;

  always_comb
  begin
    set_0 = FLAGS_RESET;
    set_0[CONVERTER_DONE_BIT]     = CONVERTER_DONE_REQ;
    set_0[SERIAL1_TRANSMIT_BIT]   = SERIAL1_TRANSMIT_REQ;
    set_0[SERIAL1_RECEIVE_BIT]    = SERIAL1_RECEIVE_REQ;
    set_0[SYNC_SERIAL1_EVENT_BIT] = SYNC_SERIAL1_EVENT_REQ;
    set_0[SYNC_SERIAL1_FAULT_BIT] = SYNC_SERIAL1_FAULT_REQ;
    set_0[TIMER_THREE_BIT]        = TIMER_THREE_REQ;
    set_0[TIMER_TWO_BIT]          = TIMER_TWO_REQ;
    set_0[COMPARE_TWO_BIT]        = COMPARE_TWO_REQ;
    set_0[CAPTURE_TWO_BIT]        = CAPTURE_TWO_REQ;
    set_0[TIMER_ONE_BIT]          = TIMER_ONE_REQ;
    set_0[COMPARE_ONE_BIT]        = COMPARE_ONE_REQ;
    set_0[CAPTURE_ONE_BIT]        = CAPTURE_ONE_REQ;
    set_0[EXT_LINE0_BIT]          = EXT_LINE0_REQ;
  end

  always_comb
  begin
    set_1 = FLAGS_RESET;
    set_1[SERIAL2_TRANSMIT_BIT]   = SERIAL2_TRANSMIT_REQ;
    set_1[SERIAL2_RECEIVE_BIT]    = SERIAL2_RECEIVE_REQ;
    set_1[EXT_LINE2_BIT]          = EXT_LINE2_REQ;
    set_1[TIMER_FIVE_BIT]         = TIMER_FIVE_REQ;
    set_1[TIMER_FOUR_BIT]         = TIMER_FOUR_REQ;
    set_1[COMPARE_FOUR_BIT]       = COMPARE_FOUR_REQ;
    set_1[COMPARE_THREE_BIT]      = COMPARE_THREE_REQ;
    set_1[EXT_LINE1_BIT]          = EXT_LINE1_REQ;
    set_1[PIN_CHANGE_BIT]         = PIN_CHANGE_REQ;
    set_1[COMPARATOR_BIT]         = COMPARATOR_REQ;
    set_1[TWOWIRE1_MASTER_BIT]    = TWOWIRE1_MASTER_REQ;
    set_1[TWOWIRE1_SLAVE_BIT]     = TWOWIRE1_SLAVE_REQ;
  end

  always_comb
  begin
    set_2 = FLAGS_RESET;
    set_2[PARALLEL_PORT_BIT]      = PARALLEL_PORT_REQ;
    set_2[COMPARE_FIVE_BIT]       = COMPARE_FIVE_REQ;
    set_2[CAPTURE_FIVE_BIT]       = CAPTURE_FIVE_REQ;
    set_2[CAPTURE_FOUR_BIT]       = CAPTURE_FOUR_REQ;
    set_2[CAPTURE_THREE_BIT]      = CAPTURE_THREE_REQ;
    set_2[SYNC_SERIAL2_EVENT_BIT] = SYNC_SERIAL2_EVENT_REQ;
    set_2[SYNC_SERIAL2_FAULT_BIT] = SYNC_SERIAL2_FAULT_REQ;
  end

  always_comb
  begin
    set_3 = FLAGS_RESET;
    set_3[CALENDAR_CLOCK_BIT]     = CALENDAR_CLOCK_REQ;
    set_3[EXT_LINE4_BIT]          = EXT_LINE4_REQ;
    set_3[EXT_LINE3_BIT]          = EXT_LINE3_REQ;
    set_3[TWOWIRE2_MASTER_BIT]    = TWOWIRE2_MASTER_REQ;
    set_3[TWOWIRE2_SLAVE_BIT]     = TWOWIRE2_SLAVE_REQ;
  end

  // ==========================================================================
  // address decode
  wire hit_f0   = (ADDR == ADDR_PENDING_FLAGS_0);
  wire hit_f1   = (ADDR == ADDR_PENDING_FLAGS_1);
  wire hit_f2   = (ADDR == ADDR_PENDING_FLAGS_2);
  wire hit_f3   = (ADDR == ADDR_PENDING_FLAGS_3);
  wire hit_st   = (ADDR == ADDR_IRQ_STATUS);
  wire hit_mask = (ADDR == ADDR_IRQ_MASK);

  wire wr_f0    = WR & hit_f0;
  wire wr_f1    = WR & hit_f1;
  wire wr_f2    = WR & hit_f2;
  wire wr_f3    = WR & hit_f3;
  wire wr_st    = WR & hit_st;
  wire wr_mask  = WR & hit_mask;

  // ==========================================================================
  // flag registers
  logic [IRFB_DW-1:0] flags_0;
  logic [IRFB_DW-1:0] flags_1;
  logic [IRFB_DW-1:0] flags_2;
  logic [IRFB_DW-1:0] flags_3;

  irfb_flag_reg #(.IMPL(IMPL_FLAGS_0)) u_flags_0 (
    .clk     (MCLK),
    .rst_n   (NRST),
    .set     (set_0),
    .wr_en   (wr_f0),
    .wr_data (WDATA),
    .flags   (flags_0)
  );

  irfb_flag_reg #(.IMPL(IMPL_FLAGS_1)) u_flags_1 (
    .clk     (MCLK),
    .rst_n   (NRST),
    .set     (set_1),
    .wr_en   (wr_f1),
    .wr_data (WDATA),
    .flags   (flags_1)
  );

  irfb_flag_reg #(.IMPL(IMPL_FLAGS_2)) u_flags_2 (
    .clk     (MCLK),
    .rst_n   (NRST),
    .set     (set_2),
    .wr_en   (wr_f2),
    .wr_data (WDATA),
    .flags   (flags_2)
  );

  irfb_flag_reg #(.IMPL(IMPL_FLAGS_3)) u_flags_3 (
    .clk     (MCLK),
    .rst_n   (NRST),
    .set     (set_3),
    .wr_en   (wr_f3),
    .wr_data (WDATA),
    .flags   (flags_3)
  );

  assign PENDING_FLAGS_0 = flags_0;
  assign PENDING_FLAGS_1 = flags_1;
  assign PENDING_FLAGS_2 = flags_2;
  assign PENDING_FLAGS_3 = flags_3;

  // ==========================================================================
  // interrupt summary: one event bit per flag register
  // only requests on implemented bits count, so stray strobes cannot raise it
  wire  [3:0] reg_evt;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;

  assign reg_evt[0] = |(set_0 & IMPL_FLAGS_0);
  assign reg_evt[1] = |(set_1 & IMPL_FLAGS_1);
  assign reg_evt[2] = |(set_2 & IMPL_FLAGS_2);
  assign reg_evt[3] = |(set_3 & IMPL_FLAGS_3);

  irfb_irq_status u_irq (
    .clk     (MCLK),
    .rst_n   (NRST),
    .evt     (reg_evt),
    .st_wr   (wr_st),
    .mask_wr (wr_mask),
    .wr_data (WDATA[3:0]),
    .status  (irq_status),
    .mask    (irq_mask),
    .irq     (IRQ)
  );

  // ==========================================================================
  // read path, data valid only in the cycle after the strobe
  logic [IRFB_DW-1:0] rdata_r;
  wire  [IRFB_DW-1:0] rd_mux;

  assign rd_mux = hit_f0   ? flags_0 :
                  hit_f1   ? flags_1 :
                  hit_f2   ? flags_2 :
                  hit_f3   ? flags_3 :
                  hit_st   ? {12'h000, irq_status} :
                  hit_mask ? {12'h000, irq_mask} :
                  READ_IDLE;

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      rdata_r <= READ_IDLE;
    else
      rdata_r <= RD ? rd_mux : READ_IDLE;
  end

  assign RDATA = rdata_r;

endmodule : irfb_top
`default_nettype wire

// >>> src/irfb_pkg.sv
// holds addresses, field positions and reset values of the interrupt request flag bank.
// assumes a 16-bit register port with a 4-bit word address.
`default_nettype none
package irfb_pkg;

  // ==========================================================================
  // register port
  localparam int          IRFB_AW = 4;
  localparam int          IRFB_DW = 16;
  localparam int          IRFB_NREG = 4;

  localparam logic [3:0]  ADDR_PENDING_FLAGS_0 = 4'h0;
  localparam logic [3:0]  ADDR_PENDING_FLAGS_1 = 4'h1;
  localparam logic [3:0]  ADDR_PENDING_FLAGS_2 = 4'h2;
  localparam logic [3:0]  ADDR_PENDING_FLAGS_3 = 4'h3;
  localparam logic [3:0]  ADDR_IRQ_STATUS      = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_MASK        = 4'h5;

  localparam logic [15:0] FLAGS_RESET      = 16'h0000;
  localparam logic [15:0] READ_IDLE        = 16'h0000;
  localparam logic [3:0]  IRQ_STATUS_RESET = 4'h0;
  localparam logic [3:0]  IRQ_MASK_RESET   = 4'h0;

  // ==========================================================================
  // implemented bits per flag register, unimplemented ones read zero
  localparam logic [15:0] IMPL_FLAGS_0 = 16'h3fef;
  localparam logic [15:0] IMPL_FLAGS_1 = 16'hfe1f;
  localparam logic [15:0] IMPL_FLAGS_2 = 16'h22e3;
  localparam logic [15:0] IMPL_FLAGS_3 = 16'h4066;

  // ==========================================================================
  // flag positions, register 0
  localparam int CONVERTER_DONE_BIT     = 13;
  localparam int SERIAL1_TRANSMIT_BIT   = 12;
  localparam int SERIAL1_RECEIVE_BIT    = 11;
  localparam int SYNC_SERIAL1_EVENT_BIT = 10;
  localparam int SYNC_SERIAL1_FAULT_BIT = 9;
  localparam int TIMER_THREE_BIT        = 8;
  localparam int TIMER_TWO_BIT          = 7;
  localparam int COMPARE_TWO_BIT        = 6;
  localparam int CAPTURE_TWO_BIT        = 5;
  localparam int TIMER_ONE_BIT          = 3;
  localparam int COMPARE_ONE_BIT        = 2;
  localparam int CAPTURE_ONE_BIT        = 1;
  localparam int EXT_LINE0_BIT          = 0;
  // register 1
  localparam int SERIAL2_TRANSMIT_BIT   = 15;
  localparam int SERIAL2_RECEIVE_BIT    = 14;
  localparam int EXT_LINE2_BIT          = 13;
  localparam int TIMER_FIVE_BIT         = 12;
  localparam int TIMER_FOUR_BIT         = 11;
  localparam int COMPARE_FOUR_BIT       = 10;
  localparam int COMPARE_THREE_BIT      = 9;
  localparam int EXT_LINE1_BIT          = 4;
  localparam int PIN_CHANGE_BIT         = 3;
  localparam int COMPARATOR_BIT         = 2;
  localparam int TWOWIRE1_MASTER_BIT    = 1;
  localparam int TWOWIRE1_SLAVE_BIT     = 0;
  // register 2
  localparam int PARALLEL_PORT_BIT      = 13;
  localparam int COMPARE_FIVE_BIT       = 9;
  localparam int CAPTURE_FIVE_BIT       = 7;
  localparam int CAPTURE_FOUR_BIT       = 6;
  localparam int CAPTURE_THREE_BIT      = 5;
  localparam int SYNC_SERIAL2_EVENT_BIT = 1;
  localparam int SYNC_SERIAL2_FAULT_BIT = 0;
  // register 3
  localparam int CALENDAR_CLOCK_BIT     = 14;
  localparam int EXT_LINE4_BIT          = 6;
  localparam int EXT_LINE3_BIT          = 5;
  localparam int TWOWIRE2_MASTER_BIT    = 2;
  localparam int TWOWIRE2_SLAVE_BIT     = 1;

endpackage : irfb_pkg
`default_nettype wire

// >>> src/irfb_flag_reg.sv
// one 16-bit pending flag register with per-bit set strobes and software load.
// assumes set strobes and write controls are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module irfb_flag_reg
  import irfb_pkg::*;
#(
  parameter logic [15:0] IMPL = 16'hffff
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // request and software side
  input  wire logic [15:0] set,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  // state
  output logic      [15:0] flags
);

  // ==========================================================================
  // per-bit flag cells
  genvar i;
  generate
    for (i = 0; i < IRFB_DW; i++)
    begin : g_bit
      if (IMPL[i])
      begin : g_impl
        logic flag_r;
        wire  flag_nxt;
        // set wins over a clearing write in the same cycle
        assign flag_nxt = (wr_en ? wr_data[i] : flag_r) | set[i];
        always_ff @(posedge clk or negedge rst_n)
        begin
          if (!rst_n)
            flag_r <= FLAGS_RESET[i];
          else
            flag_r <= flag_nxt;
        end
        assign flags[i] = flag_r;
      end
      else
      begin : g_unimpl
        assign flags[i] = 1'b0;
      end
    end
  endgenerate

endmodule : irfb_flag_reg
`default_nettype wire

// >>> src/irfb_irq_status.sv
// sticky per-register interrupt status, its mask and the level interrupt output.
// assumes one-cycle event pulses and write strobes on clk.
`timescale 1ns/1ps
`default_nettype none
module irfb_irq_status
  import irfb_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // events and software
  input  wire logic [3:0] evt,
  input  wire logic       st_wr,
  input  wire logic       mask_wr,
  input  wire logic [3:0] wr_data,
  // state
  output logic      [3:0] status,
  output logic      [3:0] mask,
  output logic            irq
);

  // ==========================================================================
  // status and mask
  logic [3:0] status_r;
  logic [3:0] mask_r;
  wire  [3:0] clr_bits;
  wire  [3:0] status_nxt;

  assign clr_bits   = st_wr ? wr_data : IRQ_STATUS_RESET;
  // a new event outlives a write-one-to-clear in the same cycle
  assign status_nxt = (status_r & ~clr_bits) | evt;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_r <= IRQ_STATUS_RESET;
      mask_r   <= IRQ_MASK_RESET;
    end
    else
    begin
      status_r <= status_nxt;
      if (mask_wr)
        mask_r <= wr_data;
    end
  end

  assign status = status_r;
  assign mask   = mask_r;
  assign irq    = |(status_r & mask_r);

endmodule : irfb_irq_status
`default_nettype wire

// >>> verification/irfb_top_sva.sv
// checker for the flag bank, seeing only the ports of irfb_top.
// assumes a single MCLK domain with NRST as its asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module irfb_top_sva
  import irfb_pkg::*;
(
  // clock and reset
  input  wire logic               MCLK,
  input  wire logic               NRST,
  // register port
  input  wire logic [IRFB_AW-1:0] ADDR,
  input  wire logic [IRFB_DW-1:0] WDATA,
  input  wire logic               WR,
  input  wire logic               RD,
  input  wire logic [IRFB_DW-1:0] RDATA,
  // a sample of the request strobes
  input  wire logic               CONVERTER_DONE_REQ,
  input  wire logic               EXT_LINE0_REQ,
  input  wire logic               SERIAL2_TRANSMIT_REQ,
  input  wire logic               TWOWIRE1_SLAVE_REQ,
  input  wire logic               PARALLEL_PORT_REQ,
  input  wire logic               CALENDAR_CLOCK_REQ,
  input  wire logic               EXT_LINE4_REQ,
  input  wire logic               EXT_LINE3_REQ,
  input  wire logic               TWOWIRE2_MASTER_REQ,
  input  wire logic               TWOWIRE2_SLAVE_REQ,
  // state
  input  wire logic [IRFB_DW-1:0] PENDING_FLAGS_0,
  input  wire logic [IRFB_DW-1:0] PENDING_FLAGS_1,
  input  wire logic [IRFB_DW-1:0] PENDING_FLAGS_2,
  input  wire logic [IRFB_DW-1:0] PENDING_FLAGS_3,
  input  wire logic               IRQ
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  a_reset_clear: assert property ($rose(NRST) |-> (PENDING_FLAGS_0 | PENDING_FLAGS_1) == 16'h0000 && !IRQ)
    else $error("flags not clear after reset");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside read cycle");
  a_read_data: assert property (RD && ADDR == 4'h2 |=> RDATA == $past(PENDING_FLAGS_2))
    else $error("read data differs from flags");
  a_unmapped_read: assert property (RD && ADDR > 4'h5 |-> ##1 RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_write_load: assert property (WR && ADDR == 4'h3 |=> PENDING_FLAGS_3 == (($past(WDATA) | {1'b0,
    $past(CALENDAR_CLOCK_REQ), 7'h00, $past(EXT_LINE4_REQ), $past(EXT_LINE3_REQ), 2'h0,
    $past(TWOWIRE2_MASTER_REQ), $past(TWOWIRE2_SLAVE_REQ), 1'b0}) & 16'h4066))
    else $error("write did not load flags");
  a_flag_hold: assert property (!($past(WR) && $past(ADDR) == 4'h0) |-> ($past(PENDING_FLAGS_0) & ~PENDING_FLAGS_0) == 16'h0000)
    else $error("flag dropped without write");
  a_unimpl_zero0: assert property ((PENDING_FLAGS_0 & 16'hc010) == 16'h0000)
    else $error("unimplemented bit set in register 0");
  a_unimpl_zero1: assert property ((PENDING_FLAGS_1 & 16'h01e0) == 16'h0000)
    else $error("unimplemented bit set in register 1");
  a_unimpl_zero2: assert property ((PENDING_FLAGS_2 & 16'hdd1c) == 16'h0000)
    else $error("unimplemented bit set in register 2");
  a_unimpl_zero3: assert property ((PENDING_FLAGS_3 & 16'hbf99) == 16'h0000)
    else $error("unimplemented bit set in register 3");
  a_conv_sets: assert property (CONVERTER_DONE_REQ |=> PENDING_FLAGS_0[13])
    else $error("converter flag not set");
  a_line0_wins: assert property (EXT_LINE0_REQ ##1 1'b1 |-> PENDING_FLAGS_0[0])
    else $error("line 0 flag not set");
  a_ser2_sets: assert property (SERIAL2_TRANSMIT_REQ |=> PENDING_FLAGS_1[15])
    else $error("serial 2 transmit flag not set");
  a_tw1_sets: assert property (TWOWIRE1_SLAVE_REQ |=> PENDING_FLAGS_1[0])
    else $error("two-wire 1 slave flag not set");
  a_par_sets: assert property (PARALLEL_PORT_REQ |=> PENDING_FLAGS_2[13])
    else $error("parallel port flag not set");
  a_cal_sets: assert property (CALENDAR_CLOCK_REQ |=> PENDING_FLAGS_3[14])
    else $error("calendar flag not set");
endmodule : irfb_top_sva

bind irfb_top irfb_top_sva u_sva (.MCLK(MCLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .CONVERTER_DONE_REQ(CONVERTER_DONE_REQ), .EXT_LINE0_REQ(EXT_LINE0_REQ),
  .SERIAL2_TRANSMIT_REQ(SERIAL2_TRANSMIT_REQ), .TWOWIRE1_SLAVE_REQ(TWOWIRE1_SLAVE_REQ),
  .PARALLEL_PORT_REQ(PARALLEL_PORT_REQ), .CALENDAR_CLOCK_REQ(CALENDAR_CLOCK_REQ),
  .EXT_LINE4_REQ(EXT_LINE4_REQ), .EXT_LINE3_REQ(EXT_LINE3_REQ), .TWOWIRE2_MASTER_REQ(TWOWIRE2_MASTER_REQ),
  .TWOWIRE2_SLAVE_REQ(TWOWIRE2_SLAVE_REQ),
  .PENDING_FLAGS_0(PENDING_FLAGS_0), .PENDING_FLAGS_1(PENDING_FLAGS_1), .PENDING_FLAGS_2(PENDING_FLAGS_2),
  .PENDING_FLAGS_3(PENDING_FLAGS_3), .IRQ(IRQ));
`default_nettype wire

// >>> verification/irfb_req_model.sv
// request source model: fires one request word after a chosen delay.
// assumes go is a one-cycle strobe and sel/bits stay put until the pulse.
`timescale 1ns/1ps
`default_nettype none
module irfb_req_model
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // command
  input  wire logic             go,
  input  wire logic [1:0]       sel,
  input  wire logic [15:0]      bits,
  input  wire logic [2:0]       dly,
  // requests per register
  output logic      [3:0][15:0] req
);
  logic       busy_r;
  logic [2:0] cnt_r;
  // ==========================================================================
  // one-cycle strobes only: a held level would hide a missing clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_r <= 1'b0;
      cnt_r  <= 3'h0;
      req    <= '0;
    end
    else
    begin
      req <= '0;
      if (go)
      begin
        busy_r <= 1'b1;
        cnt_r  <= dly;
      end
      else if (busy_r && cnt_r != 3'h0)
        cnt_r <= cnt_r - 3'h1;
      else if (busy_r)
      begin
        busy_r   <= 1'b0;
        req[sel] <= bits;
      end
    end
  end
endmodule : irfb_req_model
`default_nettype wire

// >>> verification/test_interrupt_request_flag_bank.sv
// testbench for irfb_top: register port tasks, request model, interrupt summary.
// assumes MCLK at 100 MHz and the register map 0..5 of the package.
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_request_flag_bank
  import irfb_pkg::*;
();
  localparam logic [3:0][15:0] IMPL = {16'h4066, 16'h22e3, 16'hfe1f, 16'h3fef};
  logic             mclk, nrst, bwr, brd, go, irq;
  logic [3:0]       badr;
  logic [15:0]      bdat, rdata, bits;
  logic [3:0][15:0] q, pf;
  logic [1:0]       sel;
  logic [2:0]       dly;
  int               failures, tests_run;

  // ==========================================================================
  // instances
  irfb_req_model u_src (.clk(mclk), .rst_n(nrst), .go(go), .sel(sel), .bits(bits), .dly(dly), .req(q));
  irfb_top dut (.MCLK(mclk), .NRST(nrst), .ADDR(badr), .WDATA(bdat), .WR(bwr), .RD(brd), .RDATA(rdata),
    .CONVERTER_DONE_REQ(q[0][13]), .SERIAL1_TRANSMIT_REQ(q[0][12]), .SERIAL1_RECEIVE_REQ(q[0][11]),
    .SYNC_SERIAL1_EVENT_REQ(q[0][10]), .SYNC_SERIAL1_FAULT_REQ(q[0][9]), .TIMER_THREE_REQ(q[0][8]),
    .TIMER_TWO_REQ(q[0][7]), .COMPARE_TWO_REQ(q[0][6]), .CAPTURE_TWO_REQ(q[0][5]), .TIMER_ONE_REQ(q[0][3]),
    .COMPARE_ONE_REQ(q[0][2]), .CAPTURE_ONE_REQ(q[0][1]), .EXT_LINE0_REQ(q[0][0]),
    .SERIAL2_TRANSMIT_REQ(q[1][15]), .SERIAL2_RECEIVE_REQ(q[1][14]), .EXT_LINE2_REQ(q[1][13]),
    .TIMER_FIVE_REQ(q[1][12]), .TIMER_FOUR_REQ(q[1][11]), .COMPARE_FOUR_REQ(q[1][10]),
    .COMPARE_THREE_REQ(q[1][9]), .EXT_LINE1_REQ(q[1][4]), .PIN_CHANGE_REQ(q[1][3]), .COMPARATOR_REQ(q[1][2]),
    .TWOWIRE1_MASTER_REQ(q[1][1]), .TWOWIRE1_SLAVE_REQ(q[1][0]), .PARALLEL_PORT_REQ(q[2][13]),
    .COMPARE_FIVE_REQ(q[2][9]), .CAPTURE_FIVE_REQ(q[2][7]), .CAPTURE_FOUR_REQ(q[2][6]),
    .CAPTURE_THREE_REQ(q[2][5]), .SYNC_SERIAL2_EVENT_REQ(q[2][1]), .SYNC_SERIAL2_FAULT_REQ(q[2][0]),
    .CALENDAR_CLOCK_REQ(q[3][14]), .EXT_LINE4_REQ(q[3][6]), .EXT_LINE3_REQ(q[3][5]),
    .TWOWIRE2_MASTER_REQ(q[3][2]), .TWOWIRE2_SLAVE_REQ(q[3][1]), .PENDING_FLAGS_0(pf[0]),
    .PENDING_FLAGS_1(pf[1]), .PENDING_FLAGS_2(pf[2]), .PENDING_FLAGS_3(pf[3]), .IRQ(irq));

  // ==========================================================================
  // tasks
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
  begin
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask : chk16

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
  begin
    @(posedge mclk);
    bwr  <= 1'b1;
    badr <= a;
    bdat <= d;
    @(posedge mclk);
    bwr <= 1'b0;
  end
  endtask : reg_wr

  // read data is only valid in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
  begin
    @(posedge mclk);
    brd  <= 1'b1;
    badr <= a;
    @(posedge mclk);
    brd <= 1'b0;
    #1;
    chk16(rdata, exp);
  end
  endtask : reg_rd

  task automatic ev(input logic [1:0] s, input logic [15:0] b, input logic [2:0] d);
  begin
    @(posedge mclk);
    go   <= 1'b1;
    sel  <= s;
    bits <= b;
    dly  <= d;
    @(posedge mclk);
    go <= 1'b0;
  end
  endtask : ev

  task automatic final_report;
  begin
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask : final_report

  // ==========================================================================
  // clock, watchdog, tests
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    #200000;
    failures++;
    final_report();
  end

  initial
  begin
    {nrst, bwr, brd, go, badr, bdat, bits, sel, dly, failures, tests_run} = '0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    for (int r = 0; r < 6; r++)
      reg_rd(r[3:0], 16'h0000);
    for (int r = 0; r < 4; r++)
    begin
      reg_wr(r[3:0], 16'hffff);
      reg_rd(r[3:0], IMPL[r]);
      reg_wr(r[3:0], 16'h0000);
      // flags update on the write edge itself, so look just after it
      #1;
      chk16(pf[r], 16'h0000);
    end
    // every source alone, delays from prompt to slow
    for (int r = 0; r < 4; r++)
      for (int b = 0; b < 16; b++)
      begin
        ev(r[1:0], 16'h0001 << b, b[2:0]);
        repeat (b % 8 + 2) @(posedge mclk);
        #1;
        chk16(pf[r], (16'h0001 << b) & IMPL[r]);
        chk16(pf[(r + 1) % 4], 16'h0000);
        reg_rd(r[3:0], (16'h0001 << b) & IMPL[r]);
        reg_wr(r[3:0], 16'h0000);
      end
    reg_rd(ADDR_IRQ_STATUS, 16'h000f);
    chk16({15'h0000, irq}, 16'h0000);
    reg_wr(ADDR_IRQ_MASK, 16'h0004);
    reg_rd(ADDR_IRQ_MASK, 16'h0004);
    chk16({15'h0000, irq}, 16'h0001);
    reg_wr(ADDR_IRQ_STATUS, 16'h000b);
    reg_rd(ADDR_IRQ_STATUS, 16'h0004);
    chk16({15'h0000, irq}, 16'h0001);
    reg_wr(ADDR_IRQ_STATUS, 16'h0004);
    #1;
    chk16({15'h0000, irq}, 16'h0000);
    // request in the same cycle as a clearing write
    ev(2'h0, 16'h0001, 3'h0);
    reg_wr(ADDR_PENDING_FLAGS_0, 16'h0000);
    reg_rd(ADDR_PENDING_FLAGS_0, 16'h0001);
    ev(2'h0, 16'h0002, 3'h0);
    reg_wr(ADDR_IRQ_STATUS, 16'h0001);
    reg_rd(ADDR_IRQ_STATUS, 16'h0001);
    reg_wr(ADDR_IRQ_MASK, 16'h0001);
    #1;
    chk16({15'h0000, irq}, 16'h0001);
    // unmapped place: ignored write, zero read
    reg_wr(4'hf, 16'hffff);
    reg_rd(4'h6, 16'h0000);
    reg_rd(ADDR_PENDING_FLAGS_0, 16'h0003);
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    reg_rd(ADDR_PENDING_FLAGS_0, 16'h0000);
    chk16({15'h0000, irq}, 16'h0000);
    final_report();
  end
endmodule : test_interrupt_request_flag_bank
`default_nettype wire
